// >>> coc_defs.svh
/*
  constants for the control output conditioner: register offsets,
  control bits, output type codes, reset values and timing figures.
  assumes a 4-bit register address and 16-bit register data.
*/
// Summary of operation
// - standard: low digits pick terminal, 02 current
// - heat/cool: low digits heat, high digits cool
// - codes 00 off,01 pulse,02 current,03/06 relay
// - missing terminal selected gives no output
// - position proportional variant ignores type code
// - pulse period equals cycle time 0.5-1000.0 s
// - on-time equals output percent times cycle time
// - clamp output with selected group's limit pair
// - no limits on preset output in reset
// - limit ranges; low at/above high becomes high-1
// - heat/cool uses separate heat and cool limits
// - limiter switch off bypasses limits in manual
// - heat/cool keeps limits in manual always
// - manual to auto steps output to limit
// - rate limit 0.1-100.0 %/s, zero means off
// - no rate limit in manual, reset, input error
// - heat/cool rate-limits combined result before split
// - on/off control ignores rate limit
// - manual tight shut drives current to zero, standard mode only
// - auto with tight shut holds low limit
`ifndef COC_DEFS_SVH
`define COC_DEFS_SVH
`define COC_A_CTRL    4'h0
`define COC_A_OTYPE   4'h1
`define COC_A_GRP     4'h2
`define COC_A_LIMIDX  4'h3
`define COC_A_OH      4'h4
`define COC_A_OL      4'h5
`define COC_A_OHC     4'h6
`define COC_A_OLC     4'h7
`define COC_A_RATE    4'h8
`define COC_A_CTH     4'h9
`define COC_A_CTC     4'ha
`define COC_A_PRESET  4'hb
`define COC_A_MAN     4'hc
`define COC_A_MVH     4'hd
`define COC_A_MVC     4'he
`define COC_A_STAT    4'hf
`define COC_B_HC      0
`define COC_B_MAN     1
`define COC_B_RST     2
`define COC_B_ONOFF   3
`define COC_B_LIMSW   4
`define COC_T_OFF     8'h00
`define COC_T_OPULSE  8'h01
`define COC_T_OCUR    8'h02
`define COC_T_ORELAY  8'h03
`define COC_T_CRPULSE 8'h04
`define COC_T_CRCUR   8'h05
`define COC_T_O2RELAY 8'h06
`define COC_T_RPULSE  8'h07
`define COC_T_RCUR    8'h08
`define COC_SD        12'h800
`define COC_P0        12'h000
`define COC_P100      12'h3e8
`define COC_P50       12'h1f4
`define COC_OH_MAX    12'h41a
`define COC_OH_MIN    12'hfcf
`define COC_OL_MAX    12'h419
`define COC_OL_MIN    12'hfce
`define COC_HC_OH_MIN 12'h001
`define COC_CT_MIN    14'h0005
`define COC_CT_MAX    14'h2710
`define COC_CT_RST    14'h00c8
`define COC_RATE_MAX  11'h3e8
`define COC_MS_PER_CT 7'h64
`define COC_DIV_ON    5'h0a
`define COC_MS_PER_S  32'h000003e8
`define COC_CLK_NS    10
`define COC_MS_NS     1000000
`define COC_PERIOD_MS 100
`endif

// >>> coc_pkg.sv
/*
  types shared by the control output conditioner.
  assumes values in signed tenths of a percent.
*/
`default_nettype none
package coc_pkg;
  typedef logic signed [11:0] coc_pct_t;
  typedef logic [13:0] coc_ct_t;
  typedef logic [19:0] coc_ms_t;
endpackage
`default_nettype wire

// >>> coc_top.sv
/*
  control output conditioner: limiter, rate limiter, heat/cool split,
  tight shut, time proportioning and terminal selection.
  assumes pid_result is updated by the control computation between
  control ticks and all inputs are synchronous to clock.
*/
// Design decisions made here: the plain strobed port and the register addresses.
`include "coc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module coc_top #(
  parameter int NGRP      = 8,
  parameter int MS_CYC    = `COC_MS_NS / `COC_CLK_NS,
  parameter int PERIOD_MS = `COC_PERIOD_MS,
  parameter bit HAS_OUT2  = 1'b1,
  parameter bit HAS_RET   = 1'b1,
  parameter bit POS_PROP  = 1'b0
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  // control computation
  input  wire logic [11:0] pid_result,
  input  wire logic        input_error,
  // terminals and control tick
  output logic             out_pulse,
  output logic             out_relay,
  output logic             out_cur_en,
  output logic [11:0]      out_cur,
  output logic             out2_relay,
  output logic             ret_pulse,
  output logic             ret_cur_en,
  output logic [11:0]      ret_cur,
  output logic [11:0]      pos_mv,
  output logic             tick
);
  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int PW  = $clog2(PERIOD_MS + 1);

  // software state
  logic [4:0]            ctrl_ff;
  logic [15:0]           otype_ff;
  logic [2:0]            grp_ff;
  logic [2:0]            limidx_ff;
  coc_pkg::coc_pct_t     oh_ff [NGRP];
  coc_pkg::coc_pct_t     ol_ff [NGRP];
  coc_pkg::coc_pct_t     ohc_ff;
  coc_pkg::coc_pct_t     olc_ff;
  logic [10:0]           rate_ff;
  coc_pkg::coc_ct_t      ct_ff [2];
  coc_pkg::coc_pct_t     preset_ff;
  coc_pkg::coc_pct_t     man_ff;
  logic [15:0]           rdata_ff;
  // computed state
  coc_pkg::coc_pct_t     comb_ff;
  coc_pkg::coc_pct_t     mvh_ff;
  coc_pkg::coc_pct_t     mvc_ff;
  logic                  ts_ff;
  logic [MSW-1:0]        ms_cnt_ff;
  logic [PW-1:0]         per_cnt_ff;
  logic                  tick_ff;
  coc_pkg::coc_ms_t      cyc_ff [2];
  coc_pkg::coc_ms_t      on_ff [2];
  logic [1:0]            pwm;
  logic [8:0]            term_ff;
  logic [11:0]           ocur_ff;
  logic [11:0]           rcur_ff;

  // mode bits
  wire hc    = ctrl_ff[`COC_B_HC];
  wire manm  = ctrl_ff[`COC_B_MAN];
  wire rstm  = ctrl_ff[`COC_B_RST];
  wire onoff = ctrl_ff[`COC_B_ONOFF];
  wire limsw = ctrl_ff[`COC_B_LIMSW];

  function automatic coc_pkg::coc_pct_t clip(input coc_pkg::coc_pct_t v,
      input coc_pkg::coc_pct_t lo, input coc_pkg::coc_pct_t hi);
    clip = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  // write value checks
  wire coc_pkg::coc_pct_t wpct = wdata[11:0];
  wire coc_pkg::coc_pct_t w_oh = clip(wpct, `COC_OH_MIN, `COC_OH_MAX);
  wire coc_pkg::coc_pct_t w_ol = (wpct == `COC_SD) ? `COC_SD
                               : clip(wpct, `COC_OL_MIN, `COC_OL_MAX);
  wire coc_pkg::coc_ct_t  w_ct = (wdata[13:0] < `COC_CT_MIN) ? `COC_CT_MIN
                               : (wdata[13:0] > `COC_CT_MAX) ? `COC_CT_MAX
                               : wdata[13:0];
  wire [10:0] w_rate = (wdata[10:0] > `COC_RATE_MAX) ? `COC_RATE_MAX
                     : wdata[10:0];
  wire wsel_gr = wr && (addr == `COC_A_OH || addr == `COC_A_OL);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff   <= 5'h00;
      otype_ff  <= 16'h0000;
      grp_ff    <= 3'h0;
      limidx_ff <= 3'h0;
      ohc_ff    <= `COC_P100;
      olc_ff    <= `COC_P0;
      rate_ff   <= 11'h000;
      preset_ff <= `COC_P0;
      man_ff    <= `COC_P0;
      ct_ff[0]  <= `COC_CT_RST;
      ct_ff[1]  <= `COC_CT_RST;
    end else if (wr) begin
      unique case (addr)
        `COC_A_CTRL:   ctrl_ff   <= wdata[4:0];
        `COC_A_OTYPE:  otype_ff  <= wdata;
        `COC_A_GRP:    grp_ff    <= wdata[2:0];
        `COC_A_LIMIDX: limidx_ff <= wdata[2:0];
        `COC_A_OHC:    ohc_ff    <= w_oh;
        `COC_A_OLC:    olc_ff    <= w_ol;
        `COC_A_RATE:   rate_ff   <= w_rate;
        `COC_A_CTH:    ct_ff[0]  <= w_ct;
        `COC_A_CTC:    ct_ff[1]  <= w_ct;
        `COC_A_PRESET: preset_ff <= wpct;
        `COC_A_MAN:    man_ff    <= wpct;
        default:       ;
      endcase
    end
  end

  // one limit pair per group, written through the index register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < NGRP; g++) begin
        oh_ff[g] <= `COC_P100;
        ol_ff[g] <= `COC_P0;
      end
    end else if (wsel_gr) begin
      if (addr == `COC_A_OH) begin
        oh_ff[limidx_ff] <= w_oh;
      end else begin
        ol_ff[limidx_ff] <= w_ol;
      end
    end
  end

  // read mux, data stands the cycle after the strobe
  wire [15:0] status = {13'h0000, ts_ff, pwm};
  wire [15:0] nxt_rdata =
      (addr == `COC_A_CTRL)   ? {11'h000, ctrl_ff} :
      (addr == `COC_A_OTYPE)  ? otype_ff :
      (addr == `COC_A_GRP)    ? {13'h0000, grp_ff} :
      (addr == `COC_A_LIMIDX) ? {13'h0000, limidx_ff} :
      (addr == `COC_A_OH)     ? {{4{oh_ff[limidx_ff][11]}}, oh_ff[limidx_ff]} :
      (addr == `COC_A_OL)     ? {{4{ol_ff[limidx_ff][11]}}, ol_ff[limidx_ff]} :
      (addr == `COC_A_OHC)    ? {{4{ohc_ff[11]}}, ohc_ff} :
      (addr == `COC_A_OLC)    ? {{4{olc_ff[11]}}, olc_ff} :
      (addr == `COC_A_RATE)   ? {5'h00, rate_ff} :
      (addr == `COC_A_CTH)    ? {2'h0, ct_ff[0]} :
      (addr == `COC_A_CTC)    ? {2'h0, ct_ff[1]} :
      (addr == `COC_A_PRESET) ? {{4{preset_ff[11]}}, preset_ff} :
      (addr == `COC_A_MAN)    ? {{4{man_ff[11]}}, man_ff} :
      (addr == `COC_A_MVH)    ? {{4{mvh_ff[11]}}, mvh_ff} :
      (addr == `COC_A_MVC)    ? {{4{mvc_ff[11]}}, mvc_ff} :
      status;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= rd ? nxt_rdata : 16'h0000;
    end
  end
  assign rdata = rdata_ff;

  // millisecond and control period timing
  wire ms_tick = (ms_cnt_ff == MSW'(MS_CYC - 1));
  wire nxt_tick = ms_tick && (per_cnt_ff == PW'(PERIOD_MS - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_ff  <= '0;
      per_cnt_ff <= '0;
      tick_ff    <= 1'b0;
    end else begin
      ms_cnt_ff  <= ms_tick ? '0 : ms_cnt_ff + 1'b1;
      per_cnt_ff <= nxt_tick ? '0 : (ms_tick ? per_cnt_ff + 1'b1 : per_cnt_ff);
      tick_ff    <= nxt_tick;
    end
  end
  assign tick = tick_ff;

  // limits of the selected group
  wire coc_pkg::coc_pct_t oh_g = oh_ff[grp_ff];
  wire coc_pkg::coc_pct_t ol_g = ol_ff[grp_ff];
  wire sd_on = (ol_g == `COC_SD);
  // tight shut acts as the lowest low limit outside manual
  wire coc_pkg::coc_pct_t ol_v = sd_on ? `COC_OL_MIN : ol_g;
  wire coc_pkg::coc_pct_t hi_h = (hc && oh_g < `COC_HC_OH_MIN) ? `COC_HC_OH_MIN : oh_g;
  wire coc_pkg::coc_pct_t lo_r = (hc && ol_v < `COC_P0) ? `COC_P0 : ol_v;
  wire coc_pkg::coc_pct_t lo_h = (lo_r >= hi_h) ? hi_h - 12'sd1 : lo_r;
  wire coc_pkg::coc_pct_t hi_c = (ohc_ff < `COC_HC_OH_MIN) ? `COC_HC_OH_MIN : ohc_ff;
  wire coc_pkg::coc_pct_t lo_cr = (olc_ff < `COC_P0) ? `COC_P0 : olc_ff;
  wire coc_pkg::coc_pct_t lo_c = (lo_cr >= hi_c) ? hi_c - 12'sd1 : lo_cr;

  // source selection
  wire man_sd = (man_ff == `COC_SD);
  wire coc_pkg::coc_pct_t man_v = man_sd ? `COC_OL_MIN : man_ff;
  wire coc_pkg::coc_pct_t src = rstm ? preset_ff
                              : (manm ? man_v : pid_result);
  wire nxt_ts = !hc && manm && !rstm && sd_on && man_sd;

  // rate limiter; a small rate over a short period floors to one digit
  wire [31:0] step32 = 32'(rate_ff) * 32'(PERIOD_MS) / `COC_MS_PER_S;
  wire coc_pkg::coc_pct_t step = (step32 == 32'h0) ? 12'sd1
                               : (step32 > 32'h3e8) ? `COC_P100 : step32[11:0];
  wire rate_on = (rate_ff != 11'h000) && !manm && !rstm && !input_error
                 && !onoff;
  wire signed [12:0] up_v = 13'(comb_ff) + 13'(step);
  wire signed [12:0] dn_v = 13'(comb_ff) - 13'(step);
  wire coc_pkg::coc_pct_t rated =
      !rate_on ? src :
      (13'(src) > up_v) ? up_v[11:0] :
      (13'(src) < dn_v) ? dn_v[11:0] : src;

  // limiter; after manual the clamp steps straight to the limit
  wire lim_on = !rstm && (!manm || limsw || hc);
  wire coc_pkg::coc_pct_t std_mv = lim_on ? clip(rated, lo_h, hi_h) : rated;

  // heat/cool split of the rate-limited combined value
  wire coc_pkg::coc_pct_t cmb = clip(rated, `COC_P0, `COC_P100);
  wire coc_pkg::coc_pct_t h_raw = (cmb > `COC_P50) ? 12'((cmb - `COC_P50) <<< 1) : `COC_P0;
  wire coc_pkg::coc_pct_t c_raw = (cmb < `COC_P50) ? 12'((`COC_P50 - cmb) <<< 1) : `COC_P0;
  wire coc_pkg::coc_pct_t h_mv = rstm ? rated : clip(h_raw, lo_h, hi_h);
  wire coc_pkg::coc_pct_t c_mv = rstm ? rated : clip(c_raw, lo_c, hi_c);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comb_ff <= `COC_P0;
      mvh_ff  <= `COC_P0;
      mvc_ff  <= `COC_P0;
      ts_ff   <= 1'b0;
    end else if (tick_ff) begin
      comb_ff <= rated;
      mvh_ff  <= hc ? h_mv : std_mv;
      mvc_ff  <= hc ? c_mv : `COC_P0;
      ts_ff   <= nxt_ts;
    end
  end

  // time proportioning per side
  for (genvar s = 0; s < 2; s++) begin : g_tp
    wire coc_pkg::coc_pct_t mv_s = (s == 0) ? mvh_ff : mvc_ff;
    wire coc_pkg::coc_pct_t pos = clip(mv_s, `COC_P0, `COC_P100);
    // widen before the product, a 1000.0 s cycle needs 20 bits of ms
    wire coc_pkg::coc_ms_t len = 20'(ct_ff[s]) * 20'(`COC_MS_PER_CT);
    wire [23:0] prod = 24'(pos[9:0]) * 24'(ct_ff[s]);
    wire coc_pkg::coc_ms_t nxt_on = 20'(prod / `COC_DIV_ON);
    wire wrap = ms_tick && (cyc_ff[s] >= len - 20'h00001);
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        cyc_ff[s] <= '0;
        on_ff[s]  <= '0;
      end else begin
        cyc_ff[s] <= wrap ? '0 : (ms_tick ? cyc_ff[s] + 20'h00001 : cyc_ff[s]);
        on_ff[s]  <= tick_ff ? nxt_on : on_ff[s];
      end
    end
    assign pwm[s] = (cyc_ff[s] < on_ff[s]);
    a_full_on: assert property (@(posedge clock) disable iff (!rst_n)
      (on_ff[s] >= len) |-> pwm[s])
      else $error("full on-time does not hold output on");
  end

  // terminal decode
  wire [7:0] hcode = otype_ff[7:0];
  wire [7:0] ccode = hc ? otype_ff[15:8] : `COC_T_OFF;
  wire en = !POS_PROP;
  wire h_op = (hcode == `COC_T_OPULSE);
  wire c_op = (ccode == `COC_T_OPULSE);
  wire h_oc = (hcode == `COC_T_OCUR);
  wire c_oc = (ccode == `COC_T_OCUR);
  wire h_or = (hcode == `COC_T_ORELAY);
  wire c_or = (ccode == `COC_T_ORELAY);
  wire h_o2 = (hcode == `COC_T_O2RELAY);
  wire c_o2 = (ccode == `COC_T_O2RELAY);
  wire h_rp = (hcode == `COC_T_RPULSE);
  wire c_rp = (ccode == `COC_T_CRPULSE);
  wire h_rc = (hcode == `COC_T_RCUR);
  wire c_rc = (ccode == `COC_T_CRCUR);
  wire [8:0] nxt_term = {
    en && HAS_OUT2 && ((h_o2 && pwm[0]) || (c_o2 && pwm[1])),
    en && HAS_RET && ((h_rp && pwm[0]) || (c_rp && pwm[1])),
    en && HAS_RET && (h_rc || c_rc),
    en && ((h_or && pwm[0]) || (c_or && pwm[1])),
    en && (h_oc || c_oc),
    en && ((h_op && pwm[0]) || (c_op && pwm[1])),
    3'h0};
  // current value in tenths of a percent, zero under tight shut
  wire [11:0] h_cur = ts_ff ? 12'h000 : clip(mvh_ff, `COC_OL_MIN, `COC_OH_MAX);
  wire [11:0] c_cur = clip(mvc_ff, `COC_OL_MIN, `COC_OH_MAX);
  wire [11:0] nxt_ocur = h_oc ? h_cur : (c_oc ? c_cur : 12'h000);
  wire [11:0] nxt_rcur = h_rc ? h_cur : (c_rc ? c_cur : 12'h000);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      term_ff <= 9'h000;
      ocur_ff <= 12'h000;
      rcur_ff <= 12'h000;
    end else begin
      term_ff <= nxt_term;
      ocur_ff <= nxt_ocur;
      rcur_ff <= nxt_rcur;
    end
  end
  assign out_pulse  = term_ff[3];
  assign out_cur_en = term_ff[4];
  assign out_relay  = term_ff[5];
  assign ret_cur_en = term_ff[6];
  assign ret_pulse  = term_ff[7];
  assign out2_relay = term_ff[8];
  assign out_cur    = ocur_ff;
  assign ret_cur    = rcur_ff;
  assign pos_mv     = POS_PROP ? mvh_ff : 12'h000;

  // checks
  a_lim_high: assert property (@(posedge clock) disable iff (!rst_n)
    tick_ff && lim_on && !hc |=> mvh_ff <= $past(hi_h))
    else $error("output above high limit");
  a_lim_low: assert property (@(posedge clock) disable iff (!rst_n)
    tick_ff && lim_on && !hc |=> mvh_ff >= $past(lo_h))
    else $error("output below low limit");
  a_low_fix: assert property (@(posedge clock) disable iff (!rst_n)
    lo_h < hi_h)
    else $error("effective low limit not below high limit");
  a_reset_bypass: assert property (@(posedge clock) disable iff (!rst_n)
    tick_ff && rstm |=> mvh_ff == $past(preset_ff))
    else $error("preset output was altered");
  a_rate_step: assert property (@(posedge clock) disable iff (!rst_n)
    tick_ff && rate_on |=> (comb_ff <= $past(up_v)) && (comb_ff >= $past(dn_v)))
    else $error("rate limit exceeded");
  a_rate_idle: assert property (@(posedge clock) disable iff (!rst_n)
    tick_ff && (manm || input_error || onoff) |=> comb_ff == $past(src))
    else $error("rate limit active when it must not be");
  a_ts_zero: assert property (@(posedge clock) disable iff (!rst_n)
    ts_ff && h_oc ##1 out_cur_en |-> out_cur == 12'h000)
    else $error("tight shut current not zero");
  a_no_term: assert property (@(posedge clock) disable iff (!rst_n)
    (!HAS_OUT2 || POS_PROP) |-> !out2_relay)
    else $error("output on missing terminal");
endmodule
`default_nettype wire

// >>> coc_load.sv
/*
  load model at the far side of the conditioner: a current loop
  receiver and an on-time meter on a pulse or relay terminal.
  assumes the same clock as the conditioner; clr restarts the meter.
*/
`timescale 1ns/1ps
`default_nettype none
module coc_load (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // meter control
  input  wire logic        clr,
  // terminals seen by the load
  input  wire logic        pulse,
  input  wire logic        cur_en,
  input  wire logic [11:0] cur,
  // what the load sees
  output logic [31:0]      on_cnt,
  output logic [11:0]      load_cur
);
  // an unselected loop carries no current, so the receiver reads zero
  assign load_cur = cur_en ? cur : 12'h000;

  // counts clocks with the load energised, one sample per edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt <= 32'h0000_0000;
    end else if (clr) begin
      on_cnt <= 32'h0000_0000;
    end else if (pulse) begin
      on_cnt <= on_cnt + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// >>> coc_top_test.sv
/*
  self-checking bench for the control output conditioner.
  assumes short ms and period parameters so pwm cycles fit the run;
  the load model sits on the main terminal.
*/
`include "coc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module coc_top_test;
  logic        clock       = 1'b0;
  logic        rst_n       = 1'b0;
  logic [3:0]  addr        = 4'h0;
  logic [15:0] wdata       = 16'h0000;
  logic        wr          = 1'b0;
  logic        rd          = 1'b0;
  logic [11:0] pid_result  = 12'h000;
  logic        input_error = 1'b0;
  logic        clr         = 1'b0;
  logic [15:0] rdata;
  logic        out_pulse;
  logic        out_relay;
  logic        out_cur_en;
  logic        out2_relay;
  logic        ret_pulse;
  logic        ret_cur_en;
  logic        tick;
  logic [11:0] out_cur;
  logic [11:0] ret_cur;
  logic [11:0] pos_mv;
  logic [11:0] load_cur;
  logic [31:0] on_cnt;
  logic [15:0] v;
  int          n_fail      = 0;
  int          num_checks  = 0;
  logic [7:0]  codes [7]   = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08};
  logic [5:0]  exps [7]    = '{6'h00, 6'h20, 6'h08, 6'h10, 6'h04, 6'h02, 6'h01};

  always #5 clock = ~clock;

  coc_top #(.MS_CYC(10), .PERIOD_MS(2)) uut (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pid_result(pid_result), .input_error(input_error),
    .out_pulse(out_pulse), .out_relay(out_relay), .out_cur_en(out_cur_en),
    .out_cur(out_cur), .out2_relay(out2_relay), .ret_pulse(ret_pulse),
    .ret_cur_en(ret_cur_en), .ret_cur(ret_cur), .pos_mv(pos_mv), .tick(tick)
  );

  coc_load u_load (
    .clock(clock), .rst_n(rst_n), .clr(clr), .pulse(out_pulse),
    .cur_en(out_cur_en), .cur(out_cur), .on_cnt(on_cnt), .load_cur(load_cur)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic sp(input logic [11:0] p);
    @(posedge clock);
    pid_result <= p;
  endtask

  // waits n control ticks, then lets mv and terminals settle
  task automatic tk(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        @(posedge clock);
        #1;
        i++;
      end while (tick !== 1'b1 && i < 100);
      if (i >= 100) begin
        n_fail++;
        wrap_up;
      end
    end
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic mv(input string nm, input logic [15:0] e);
    rd_reg(`COC_A_MVH, v);
    chk(nm, {16'h0000, v}, {16'h0000, e});
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(`COC_A_OH, v);  chk("oh reset", {16'h0, v}, 32'h3e8);
    rd_reg(`COC_A_OL, v);  chk("ol reset", {16'h0, v}, 32'h0);
    rd_reg(`COC_A_CTH, v); chk("ct heat reset", {16'h0, v}, 32'hc8);
    rd_reg(`COC_A_CTC, v); chk("ct cool reset", {16'h0, v}, 32'hc8);
    // full output first, so every pulse terminal is on for whole cycles
    wr_reg(`COC_A_CTH, 16'h0005);
    sp(12'h3e8);
    repeat (6000) @(posedge clock);
    for (int k = 0; k < 7; k++) begin
      wr_reg(`COC_A_OTYPE, {8'h00, codes[k]});
      tk(2);
      chk("terminals", {26'h0, out_pulse, out_relay, out_cur_en, out2_relay, ret_pulse,
          ret_cur_en}, {26'h0, exps[k]});
    end
    wr_reg(`COC_A_OTYPE, 16'h0001);
    sp(12'h1f4);
    repeat (11000) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (5000) @(posedge clock);
    #1;
    chk("on time", on_cnt, 32'd2500);
    sp(12'hf9c);
    wr_reg(`COC_A_OL, 16'h03e8);
    tk(1); mv("low at high", 16'h03e7);
    wr_reg(`COC_A_OL, 16'h0000);
    wr_reg(`COC_A_LIMIDX, 16'h0001);
    wr_reg(`COC_A_OH, 16'h0258);
    wr_reg(`COC_A_GRP, 16'h0001);
    sp(12'h384);
    tk(1); mv("group high", 16'h0258);
    wr_reg(`COC_A_CTRL, 16'h0002);
    wr_reg(`COC_A_MAN, 16'h0384);
    tk(1); mv("manual bypass", 16'h0384);
    wr_reg(`COC_A_CTRL, 16'h0012);
    tk(1); mv("manual limited", 16'h0258);
    wr_reg(`COC_A_CTRL, 16'h0002);
    tk(1);
    wr_reg(`COC_A_CTRL, 16'h0000);
    tk(1); mv("auto step", 16'h0258);
    wr_reg(`COC_A_PRESET, 16'h041a);
    wr_reg(`COC_A_CTRL, 16'h0004);
    tk(1); mv("preset", 16'h041a);
    wr_reg(`COC_A_CTRL, 16'h0000);
    wr_reg(`COC_A_GRP, 16'h0000);
    sp(12'h000);
    tk(2); mv("rate base", 16'h0000);
    // a 100.0 %/s rate over a 2 ms period allows two digits a period
    wr_reg(`COC_A_RATE, 16'h03e8);
    sp(12'h1f4);
    tk(1); mv("rate step", 16'h0002);
    tk(1); mv("rate step two", 16'h0004);
    @(posedge clock);
    input_error <= 1'b1;
    tk(1); mv("rate on error", 16'h01f4);
    @(posedge clock);
    input_error <= 1'b0;
    wr_reg(`COC_A_CTRL, 16'h0008);
    sp(12'h3e8);
    tk(1); mv("on off jump", 16'h03e8);
    wr_reg(`COC_A_MAN, 16'h0000);
    wr_reg(`COC_A_CTRL, 16'h0002);
    tk(1); mv("rate in manual", 16'h0000);
    wr_reg(`COC_A_RATE, 16'h0000);
    wr_reg(`COC_A_OTYPE, 16'h0002);
    wr_reg(`COC_A_LIMIDX, 16'h0000);
    wr_reg(`COC_A_OL, 16'h0800);
    wr_reg(`COC_A_MAN, 16'h0800);
    tk(1); chk("tight shut current", {20'h0, load_cur}, 32'h0);
    rd_reg(`COC_A_STAT, v); chk("tight shut flag", {16'h0, v & 16'h0004}, 32'h4);
    wr_reg(`COC_A_CTRL, 16'h0000);
    sp(12'hf9c);
    tk(1); mv("shut level auto", 16'hffce);
    chk("shut auto current", {20'h0, load_cur}, 32'hfce);
    wr_reg(`COC_A_OL, 16'h0000);
    wr_reg(`COC_A_CTC, 16'h0005);
    wr_reg(`COC_A_OTYPE, 16'h0602);
    wr_reg(`COC_A_CTRL, 16'h0001);
    sp(12'h3e8);
    tk(1); mv("heat side", 16'h03e8);
    chk("heat current", {20'h0, load_cur}, 32'h3e8);
    sp(12'h000);
    tk(1);
    rd_reg(`COC_A_MVC, v); chk("cool side", {16'h0, v}, 32'h3e8);
    repeat (11000) @(posedge clock);
    #1;
    chk("cool relay", {31'h0, out2_relay}, 32'h1);
    wrap_up;
  end
endmodule
`default_nettype wire
